/* File: csi_defs.svh */
`ifndef CSI_DEFS_SVH
`define CSI_DEFS_SVH

// ****************************************
// Processor clock and stall timing
// ****************************************
`define CSI_CPU_CLK_HALF      3'd4
`define CSI_CSR_STALL_CYCLES  3'd3

// ****************************************
// Processor address decode
// ****************************************
`define CSI_SPACE_MSB         31
`define CSI_SPACE_LSB         28
`define CSI_SPACE_CSR         4'h4
`define CSI_SPACE_MODE        4'h5
`define CSI_SPACE_PCI_MIN     4'h8
`define CSI_ARRAY_MSB         27
`define CSI_ARRAY_LSB         26
`define CSI_CSR_IDX_MSB       10
`define CSI_CSR_IDX_LSB       2
`define CSI_CSR_COUNT         9'h004
`define CSI_CSR_RESET         32'h0000_0000

// ****************************************
// FIFO sizes in bytes and 32-bit words
// ****************************************
`define CSI_OB_BYTES          256
`define CSI_IB_BYTES          256
`define CSI_RF_BYTES          128
`define CSI_WORD_BYTES        4

// ****************************************
// SDRAM command and init
// ****************************************
`define CSI_CMD_NOP           3'h7
`define CSI_CMD_PRECHARGE     3'h2
`define CSI_ALL_BANKS         2'h3
`define CSI_ALL_BANKS_HIGH    5'h1F
`define CSI_INIT_COMMANDS     3'h4

`endif

/* File: csi_pkg.sv */
package csi_pkg;

   typedef enum logic [3:0] {
      sIdle,
      sCsr,
      sPrecharge,
      sObAddr,
      sObData,
      sIbWait,
      sIbData,
      sDone
   } csi_state_type;

   typedef struct packed {
      logic        writeEn;
      logic [31:0] address;
      logic [31:0] data;
   } csi_cpu_req_type;

   typedef struct packed {
      logic        isAddress;
      logic [31:0] word;
   } csi_fifo_word_type;

endpackage

/* File: csi_fifo.sv */
module csi_fifo
   import csi_pkg::*;
#(
   parameter int DEPTH = 64
)
(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              pushValid,
   input  csi_fifo_word_type      pushData,
   output logic                   pushReady,
   input  wire logic              popReq,
   output logic                   popAvail,
   output csi_fifo_word_type      popData,
   output logic                   popValid
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   csi_fifo_word_type mem [DEPTH];
   logic [AW-1:0]     wrPtr_reg;
   logic [AW-1:0]     rdPtr_reg;
   logic [AW:0]       count_reg;
   logic [AW:0]       count_next;
   logic              doPush;
   logic              doPop;

   assign doPush = pushValid && pushReady;
   assign doPop  = popReq && popAvail;

   always_comb
   begin
      count_next = count_reg;
      if (doPush && !doPop)
         count_next = count_reg + (AW+1)'(1);
      else if (doPop && !doPush)
         count_next = count_reg - (AW+1)'(1);
   end

   // ****************************************
   // Pointers and honest full/empty flags
   // ****************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
         pushReady <= 1'b1;
         popAvail  <= 1'b0;
         popValid  <= 1'b0;
         popData   <= '0;
      end
      else if (ce)
      begin
         count_reg <= count_next;
         pushReady <= (count_next != FULL);
         popAvail  <= (count_next != '0);
         popValid  <= doPop;
         if (doPush)
            wrPtr_reg <= wrPtr_reg + AW'(1);
         if (doPop)
         begin
            rdPtr_reg <= rdPtr_reg + AW'(1);
            popData   <= mem[rdPtr_reg];
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (ce && doPush)
         mem[wrPtr_reg] <= pushData;
   end

endmodule

/* File: csi_front_end.sv */
// What this block does
// R1 - Outbound and inbound FIFOs of 256 bytes, PCI read FIFO of 128 bytes.
// R2 - Outbound carries addresses and write data; inbound returns processor read data.
// R3 - Processor memory request stalls it by holding generated processor clock high.
// R4 - Stall length depends on target address space and activity in progress.
// R5 - Register index is address bits 10:2; read data driven on 32-bit bus.
// R6 - Register write normally stalls three cycles, possibly longer.
// R7 - Register read normally stalls three cycles.
// R8 - Writes to unimplemented register offsets are dropped silently.
// R9 - Reads of unimplemented register offsets return zero.
// R10 - Read in one of four mode regions precharges all banks of that array.
// R11 - Stall during precharge, ignore low address bits; software ignores read data.
// R12 - Precharge drives bank address 11 and multiplexed address 12:8 all ones.
// R13 - Software precharges each array before mode set or other access.
// R14 - Byte masks held high from reset until four init commands counted.
// R15 - Init counter advances on precharge, mode register set and refresh.
// R16 - Software should precharge every fitted array even if fewer than four.
// R17 - After completion the stretched high phase ends and clock toggles again.
`include "csi_defs.svh"

module csi_front_end
   import csi_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic         cpu_mem_request_n,
   input  wire logic         cpuWriteEn,
   input  wire logic [31:0]  cpuAddress,
   input  wire logic [31:0]  cpuWriteData,
   output logic              cpuClk,
   output logic [31:0]       cpuReadData,
   output logic              cpuDataOe,
   input  wire logic         modeSetIssued,
   input  wire logic         refreshIssued,
   output logic [2:0]        sdramCmd,
   output logic [3:0]        sdramChipSelN,
   output logic [1:0]        sdramBank,
   output logic [12:0]       sdram_mux_address,
   output logic [3:0]        sdramByteMask,
   input  wire logic         obPopReq,
   output logic              obPopAvail,
   output csi_fifo_word_type obPopData,
   output logic              obPopValid,
   input  wire logic         ibPushValid,
   input  csi_fifo_word_type ibPushData,
   output logic              ibPushReady,
   input  wire logic         rfPushValid,
   input  csi_fifo_word_type rfPushData,
   output logic              rfPushReady,
   input  wire logic         rfPopReq,
   output logic              rfPopAvail,
   output csi_fifo_word_type rfPopData,
   output logic              rfPopValid
);

   csi_state_type     state_reg;
   csi_cpu_req_type   req_reg;
   logic [2:0]        halfCount_reg;
   logic [2:0]        stallCount_reg;
   logic [2:0]        initCount_reg;
   logic [2:0]        initEvents;
   logic              reqS0_reg;
   logic              reqS1_reg;
   logic              reqS2_reg;
   logic              reqActive_reg;
   logic              startReq;
   logic              holdHigh;
   logic [31:0]       csr_reg [`CSI_CSR_COUNT];
   logic [8:0]        csrIndex;
   logic              obPushValid;
   logic              obPushReady;
   csi_fifo_word_type obPushData;
   logic              ibPopReq;
   logic              ibPopAvail;
   csi_fifo_word_type ibPopData;
   logic              ibPopValid;

   function automatic logic csrImplemented(input logic [8:0] index);
      return index < `CSI_CSR_COUNT;
   endfunction

   // ****************************************
   // Request pin synchroniser
   // ****************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         reqS0_reg     <= 1'b1;
         reqS1_reg     <= 1'b1;
         reqS2_reg     <= 1'b1;
         reqActive_reg <= 1'b0;
      end
      else if (ce)
      begin
         reqS0_reg <= cpu_mem_request_n;
         reqS1_reg <= reqS0_reg;
         reqS2_reg <= reqS1_reg;
         if (reqS1_reg == reqS2_reg)
            reqActive_reg <= ~reqS2_reg;
      end
   end

   // ****************************************
   // Processor clock generation and stretch
   // ****************************************
   assign startReq = (state_reg == sIdle) && cpuClk && reqActive_reg
                     && (halfCount_reg == `CSI_CPU_CLK_HALF - 3'd1);
   assign holdHigh = startReq || ((state_reg != sIdle) && (state_reg != sDone)); // see R3

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cpuClk        <= 1'b0;
         halfCount_reg <= '0;
      end
      else if (ce && !holdHigh) // see R17
      begin
         if (halfCount_reg == `CSI_CPU_CLK_HALF - 3'd1)
         begin
            halfCount_reg <= '0;
            cpuClk        <= ~cpuClk;
         end
         else
            halfCount_reg <= halfCount_reg + 3'd1;
      end
   end

   // ****************************************
   // Transaction sequencer
   // ****************************************
   assign csrIndex = req_reg.address[`CSI_CSR_IDX_MSB:`CSI_CSR_IDX_LSB]; // see R5

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_reg      <= sIdle;
         req_reg        <= '0;
         stallCount_reg <= '0;
      end
      else if (ce)
      begin
         unique case (state_reg)
            sIdle:
               if (startReq)
               begin
                  req_reg        <= '{cpuWriteEn, cpuAddress, cpuWriteData};
                  stallCount_reg <= '0;
                  // Decode by space sets the stall length
                  if (cpuAddress[`CSI_SPACE_MSB:`CSI_SPACE_LSB] == `CSI_SPACE_CSR) // see R4
                     state_reg <= sCsr;
                  else if (cpuAddress[`CSI_SPACE_MSB:`CSI_SPACE_LSB] == `CSI_SPACE_MODE
                           && !cpuWriteEn) // see R10
                     state_reg <= sPrecharge;
                  else if (cpuAddress[`CSI_SPACE_MSB:`CSI_SPACE_LSB] >= `CSI_SPACE_PCI_MIN)
                     state_reg <= sObAddr;
                  else
                     state_reg <= sDone;
               end
            sCsr:
               if (stallCount_reg == `CSI_CSR_STALL_CYCLES - 3'd1) // see R6, R7
                  state_reg <= sDone;
               else
                  stallCount_reg <= stallCount_reg + 3'd1;
            sPrecharge:
               if (stallCount_reg == 3'd1) // see R11
                  state_reg <= sDone;
               else
                  stallCount_reg <= stallCount_reg + 3'd1;
            sObAddr:
               if (obPushReady)
                  state_reg <= req_reg.writeEn ? sObData : sIbWait;
            sObData:
               if (obPushReady)
                  state_reg <= sDone;
            sIbWait:
               if (ibPopAvail)
                  state_reg <= sIbData;
            sIbData:
               if (ibPopValid)
                  state_reg <= sDone;
            sDone:
               state_reg <= sIdle;
         endcase
      end
   end

   // ****************************************
   // Control and status registers
   // ****************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         for (int i = 0; i < `CSI_CSR_COUNT; i++)
            csr_reg[i] <= `CSI_CSR_RESET;
      end
      else if (ce && state_reg == sCsr && req_reg.writeEn
               && stallCount_reg == `CSI_CSR_STALL_CYCLES - 3'd1
               && csrImplemented(csrIndex)) // see R8
         csr_reg[csrIndex[1:0]] <= req_reg.data;
   end

   // ****************************************
   // Processor read data bus
   // ****************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cpuReadData <= '0;
         cpuDataOe   <= 1'b0;
      end
      else if (ce)
      begin
         if (startReq)
            cpuDataOe <= 1'b0;
         else if (state_reg == sCsr && !req_reg.writeEn
                  && stallCount_reg == `CSI_CSR_STALL_CYCLES - 3'd1)
         begin
            cpuDataOe   <= 1'b1;
            cpuReadData <= csrImplemented(csrIndex) ? csr_reg[csrIndex[1:0]] : '0; // see R5, R9
         end
         else if (state_reg == sIbData && ibPopValid) // see R2
         begin
            cpuDataOe   <= 1'b1;
            cpuReadData <= ibPopData.word;
         end
         else if (state_reg == sPrecharge && stallCount_reg == 3'd1)
         begin
            cpuDataOe   <= 1'b1;
            cpuReadData <= '0;
         end
      end
   end

   // ****************************************
   // SDRAM all-banks precharge command
   // ****************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sdramCmd          <= `CSI_CMD_NOP;
         sdramChipSelN     <= 4'hF;
         sdramBank         <= 2'h0;
         sdram_mux_address <= 13'h0000;
      end
      else if (ce)
      begin
         if (state_reg == sPrecharge && stallCount_reg == 3'd0)
         begin
            sdramCmd          <= `CSI_CMD_PRECHARGE; // see R10
            sdramChipSelN     <= ~(4'h1 << req_reg.address[`CSI_ARRAY_MSB:`CSI_ARRAY_LSB]);
            sdramBank         <= `CSI_ALL_BANKS; // see R12
            sdram_mux_address <= {`CSI_ALL_BANKS_HIGH, 8'h00}; // see R11, R12
         end
         else
         begin
            sdramCmd          <= `CSI_CMD_NOP;
            sdramChipSelN     <= 4'hF;
            sdramBank         <= 2'h0;
            sdram_mux_address <= 13'h0000;
         end
      end
   end

   // ****************************************
   // Byte mask release after init commands
   // ****************************************
   assign initEvents = {2'b00, state_reg == sPrecharge && stallCount_reg == 3'd0}
                       + {2'b00, modeSetIssued} + {2'b00, refreshIssued}; // see R15

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         initCount_reg <= '0;
         sdramByteMask <= 4'hF;
      end
      else if (ce)
      begin
         if (initCount_reg + initEvents >= `CSI_INIT_COMMANDS)
            initCount_reg <= `CSI_INIT_COMMANDS;
         else
            initCount_reg <= initCount_reg + initEvents;
         sdramByteMask <= (initCount_reg < `CSI_INIT_COMMANDS) ? 4'hF : 4'h0; // see R14
      end
   end

   // ****************************************
   // Transaction FIFOs
   // ****************************************
   assign obPushValid = (state_reg == sObAddr) || (state_reg == sObData);
   assign obPushData  = (state_reg == sObAddr) ? csi_fifo_word_type'{1'b1, req_reg.address}
                                               : csi_fifo_word_type'{1'b0, req_reg.data}; // see R2
   assign ibPopReq    = (state_reg == sIbWait) && ibPopAvail;

   csi_fifo #(.DEPTH(`CSI_OB_BYTES / `CSI_WORD_BYTES)) outboundFifo // see R1
   (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .ce        (ce),
      .pushValid (obPushValid),
      .pushData  (obPushData),
      .pushReady (obPushReady),
      .popReq    (obPopReq),
      .popAvail  (obPopAvail),
      .popData   (obPopData),
      .popValid  (obPopValid)
   );

   csi_fifo #(.DEPTH(`CSI_IB_BYTES / `CSI_WORD_BYTES)) inboundFifo // see R1
   (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .ce        (ce),
      .pushValid (ibPushValid),
      .pushData  (ibPushData),
      .pushReady (ibPushReady),
      .popReq    (ibPopReq),
      .popAvail  (ibPopAvail),
      .popData   (ibPopData),
      .popValid  (ibPopValid)
   );

   csi_fifo #(.DEPTH(`CSI_RF_BYTES / `CSI_WORD_BYTES)) readFifo // see R1
   (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .ce        (ce),
      .pushValid (rfPushValid),
      .pushData  (rfPushData),
      .pushReady (rfPushReady),
      .popReq    (rfPopReq),
      .popAvail  (rfPopAvail),
      .popData   (rfPopData),
      .popValid  (rfPopValid)
   );

endmodule

/* File: csi_front_end_chk.sv */
module csi_front_end_chk
   import csi_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        cpuClk,
   input wire logic [31:0] cpuAddress,
   input wire logic [31:0] cpuReadData,
   input wire logic        cpuDataOe,
   input wire logic        modeSetIssued,
   input wire logic        refreshIssued,
   input wire logic [2:0]  sdramCmd,
   input wire logic [3:0]  sdramChipSelN,
   input wire logic [1:0]  sdramBank,
   input wire logic [12:0] sdram_mux_address,
   input wire logic [3:0]  sdramByteMask,
   input wire logic        obPopValid
);
   // ********
   // Init command count
   // ********
   logic [2:0] initCount_reg;
   logic [2:0] initCount_next;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   always_comb
   begin
      initCount_next = initCount_reg + 3'(sdramCmd == 3'h2) + 3'(modeSetIssued)
                       + 3'(refreshIssued);
      if (initCount_next > 3'h4)
         initCount_next = 3'h4;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         initCount_reg <= 3'h0;
      else
         initCount_reg <= initCount_next;
   end

   property p_mask_hold;
      initCount_reg < 3'h4 |-> sdramByteMask == 4'hF;
   endproperty
   a_mask_hold: assert property (p_mask_hold) else $error("byte mask released early");
   property p_mask_free;
      initCount_reg == 3'h4 |-> ##[0:2] sdramByteMask == 4'h0;
   endproperty
   a_mask_free: assert property (p_mask_free) else $error("byte mask not released");
   property p_pre_addr;
      sdramCmd == 3'h2 |-> sdramBank == 2'h3 && sdram_mux_address == 13'h1F00
         && $countones(~sdramChipSelN) == 1;
   endproperty
   a_pre_addr: assert property (p_pre_addr) else $error("precharge address wrong");
   property p_pre_pulse;
      sdramCmd == 3'h2 |=> sdramCmd == 3'h7;
   endproperty
   a_pre_pulse: assert property (p_pre_pulse) else $error("precharge not one cycle");
   property p_pre_stall;
      sdramCmd == 3'h2 |-> cpuClk[*2] ##[1:2] !cpuClk;
   endproperty
   a_pre_stall: assert property (p_pre_stall) else $error("precharge stall wrong");
   property p_high_min;
      $rose(cpuClk) |-> cpuClk[*4];
   endproperty
   a_high_min: assert property (p_high_min) else $error("clock high too short");
   property p_low_len;
      $fell(cpuClk) |-> !cpuClk[*4] ##1 cpuClk;
   endproperty
   a_low_len: assert property (p_low_len) else $error("clock low phase wrong");
   property p_csr_zero;
      $rose(cpuDataOe) && cpuAddress[31:28] == 4'h4 && cpuAddress[10:2] >= 9'h004
         |-> cpuReadData == 32'h0;
   endproperty
   a_csr_zero: assert property (p_csr_zero) else $error("empty register not zero");
   property p_csr_end;
      $rose(cpuDataOe) && cpuAddress[31:28] == 4'h4 |-> ##[1:2] !cpuClk;
   endproperty
   a_csr_end: assert property (p_csr_end) else $error("register stall too long");

   c_pre: cover property (sdramCmd == 3'h2);
   c_csr: cover property ($rose(cpuDataOe) && cpuAddress[31:28] == 4'h4);
   c_ob: cover property (obPopValid);
endmodule

bind csi_front_end csi_front_end_chk u_chk (
   .clk_sys           (clk_sys),
   .rst               (rst),
   .cpuClk            (cpuClk),
   .cpuAddress        (cpuAddress),
   .cpuReadData       (cpuReadData),
   .cpuDataOe         (cpuDataOe),
   .modeSetIssued     (modeSetIssued),
   .refreshIssued     (refreshIssued),
   .sdramCmd          (sdramCmd),
   .sdramChipSelN     (sdramChipSelN),
   .sdramBank         (sdramBank),
   .sdram_mux_address (sdram_mux_address),
   .sdramByteMask     (sdramByteMask),
   .obPopValid        (obPopValid)
);

/* File: csi_cpu_model.sv */
module csi_cpu_model
   import csi_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        cpuClk,
   input wire logic        go,
   input csi_cpu_req_type  req,
   output logic            cpu_mem_request_n,
   output logic            cpuWriteEn,
   output logic [31:0]     cpuAddress,
   output logic [31:0]     cpuWriteData,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 1ns;

   // Waits for the next falling edge of the processor clock
   task automatic wait_fall();
      int k;
      k = 0;
      while (cpuClk !== 1'b1 && k < 300)
      begin
         @(posedge clk_sys);
         k++;
      end
      while (cpuClk !== 1'b0 && k < 600)
      begin
         @(posedge clk_sys);
         k++;
      end
   endtask

   initial
   begin
      cpu_mem_request_n = 1'b1;
      {cpuWriteEn, cpuAddress, cpuWriteData} = '0;
      busy = 1'b0;
      forever
      begin
         @(posedge clk_sys iff go);
         #1 busy = 1'b1;
         wait_fall();
         #1 cpu_mem_request_n = 1'b0;
         {cpuWriteEn, cpuAddress, cpuWriteData} = req;
         wait_fall();
         #1 cpu_mem_request_n = 1'b1;
         // Released bus shows no stale value
         cpuAddress = ~cpuAddress;
         cpuWriteData = ~cpuWriteData;
         busy = 1'b0;
      end
   end
endmodule

/* File: csi_front_end_tb_top.sv */
module csi_front_end_tb_top
   import csi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk_sys, rst, ce, cpu_mem_request_n, cpuWriteEn, cpuClk, cpuDataOe, go, busy, drain;
   logic modeSetIssued, refreshIssued, obPopReq, obPopAvail, obPopValid, ibPushValid;
   logic ibPushReady, rfPushValid, rfPushReady, rfPopReq, rfPopAvail, rfPopValid;
   logic prevOe = 1'b0;
   logic [31:0]       cpuAddress, cpuWriteData, cpuReadData, a, d;
   logic [31:0]       w [6];
   logic [2:0]        sdramCmd;
   logic [3:0]        sdramChipSelN, sdramByteMask;
   logic [1:0]        sdramBank;
   logic [12:0]       sdram_mux_address;
   csi_fifo_word_type obPopData, ibPushData, rfPushData, rfPopData;
   csi_cpu_req_type   req;
   logic [33:0]       rdQ [$], obQ [$], rfQ [$], csQ [$];
   int                fails, tests_run, cyc, n, i;

   csi_front_end DUT (
      .clk_sys(clk_sys), .rst(rst), .ce(ce), .cpu_mem_request_n(cpu_mem_request_n),
      .cpuWriteEn(cpuWriteEn), .cpuAddress(cpuAddress), .cpuWriteData(cpuWriteData),
      .cpuClk(cpuClk), .cpuReadData(cpuReadData), .cpuDataOe(cpuDataOe),
      .modeSetIssued(modeSetIssued), .refreshIssued(refreshIssued), .sdramCmd(sdramCmd),
      .sdramChipSelN(sdramChipSelN), .sdramBank(sdramBank),
      .sdram_mux_address(sdram_mux_address), .sdramByteMask(sdramByteMask),
      .obPopReq(obPopReq), .obPopAvail(obPopAvail), .obPopData(obPopData),
      .obPopValid(obPopValid), .ibPushValid(ibPushValid), .ibPushData(ibPushData),
      .ibPushReady(ibPushReady), .rfPushValid(rfPushValid), .rfPushData(rfPushData),
      .rfPushReady(rfPushReady), .rfPopReq(rfPopReq), .rfPopAvail(rfPopAvail),
      .rfPopData(rfPopData), .rfPopValid(rfPopValid));

   csi_cpu_model u_cpu (
      .clk_sys(clk_sys), .cpuClk(cpuClk), .go(go), .req(req),
      .cpu_mem_request_n(cpu_mem_request_n), .cpuWriteEn(cpuWriteEn),
      .cpuAddress(cpuAddress), .cpuWriteData(cpuWriteData), .busy(busy));

   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // ********
   // Shared tasks
   // ********
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
      tests_run++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic take(ref logic [33:0] q [$], input string nm, input logic [32:0] g);
      logic [33:0] e;
      if (q.size() == 0)
      begin
         fails++;
         $display("unexpected %s expected none seen %h", nm, g);
      end
      else
      begin
         e = q.pop_front();
         if (e[33])
            chk(nm, e[32:0], g);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask

   task automatic do_reset();
      rst = 1'b1;
      tick(20);
      rst = 1'b0;
   endtask

   task automatic cpu(input logic we, input logic [31:0] ad, input logic [31:0] dt);
      int k;
      k = 0;
      tick(1);
      req = '{we, ad, dt};
      go = 1'b1;
      tick(1);
      go = 1'b0;
      @(posedge clk_sys);
      while (busy && k < 400)
      begin
         @(posedge clk_sys);
         k++;
      end
      #1;
      chk("cpu done", 33'h0, {32'h0, busy});
   endtask

   task automatic push(input bit toRf, output int cnt);
      logic [31:0] v;
      cnt = 0;
      while (cnt < 80 && (toRf ? rfPushReady : ibPushReady) === 1'b1)
      begin
         v = toRf ? $urandom : 32'hA5A50000 + cnt;
         if (toRf)
            rfQ.push_back({2'b10, v});
         rfPushData = '{1'b0, v};
         ibPushData = '{1'b0, v};
         rfPushValid = toRf;
         ibPushValid = !toRf;
         tick(1);
         cnt++;
      end
      rfPushValid = 1'b0;
      ibPushValid = 1'b0;
   endtask

   function automatic logic [31:0] csr_addr(input int k);
      logic [8:0] x;
      x = k < 4 ? 9'(k) : (k == 4 ? 9'h004 : 9'h1FF);
      return {4'h4, 17'($urandom), x, 2'($urandom)};
   endfunction

   // ********
   // Result watch, pop stalls, timeout
   // ********
   always @(posedge clk_sys)
   begin
      if (cpuDataOe === 1'b1 && !prevOe)
         take(rdQ, "read data", {1'b0, cpuReadData});
      if (obPopValid === 1'b1)
         take(obQ, "outbound word", obPopData);
      if (rfPopValid === 1'b1)
         take(rfQ, "read fifo word", rfPopData);
      if (sdramCmd === 3'h2)
         take(csQ, "array select", {29'h0, sdramChipSelN});
      prevOe <= cpuDataOe;
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         give_verdict();
      end
      #1 obPopReq = obPopAvail === 1'b1 && !obPopReq && $urandom_range(1);
      rfPopReq = drain && rfPopAvail === 1'b1 && !rfPopReq && $urandom_range(1);
   end

   // ********
   // Main sequence
   // ********
   initial
   begin
      {rst, ce} = 2'b11;
      {go, drain, modeSetIssued, refreshIssued, obPopReq, rfPopReq} = '0;
      {ibPushValid, rfPushValid, ibPushData, rfPushData, req} = '0;
      void'($urandom(32'h4A38EBC3));
      do_reset();
      chk("byte mask", 33'hF, sdramByteMask);
      for (i = 0; i < 4; i++)
      begin
         if (i == 2)
         begin
            modeSetIssued = 1'b1;
            tick(1);
            modeSetIssued = 1'b0;
            tick(3);
            chk("byte mask", 33'hF, sdramByteMask);
            refreshIssued = 1'b1;
            tick(1);
            refreshIssued = 1'b0;
            tick(3);
            chk("byte mask", 33'h0, sdramByteMask);
         end
         csQ.push_back({30'h20000000, ~(4'h1 << i)});
         rdQ.push_back(34'h0);
         cpu(1'b0, {4'h5, i[1:0], 26'($urandom)}, $urandom);
      end
      for (i = 0; i < 6; i++)
      begin
         w[i] = $urandom;
         cpu(1'b1, csr_addr(i), w[i]);
      end
      for (i = 0; i < 6; i++)
      begin
         rdQ.push_back({2'b10, i < 4 ? w[i] : 32'h0});
         cpu(1'b0, csr_addr(i), $urandom);
      end
      a = {4'h8, 28'($urandom)};
      d = $urandom;
      obQ.push_back({2'b11, a});
      obQ.push_back({2'b10, d});
      cpu(1'b1, a, d);
      push(1'b1, n);
      chk("read fifo depth", 33'd32, 33'(n));
      drain = 1'b1;
      tick(300);
      chk("read fifo empty", 33'h0, {32'h0, rfPopAvail});
      push(1'b0, n);
      chk("inbound depth", 33'd64, 33'(n));
      a = {4'hC, 28'($urandom)};
      obQ.push_back({2'b11, a});
      rdQ.push_back({2'b10, 32'hA5A50000});
      cpu(1'b0, a, 32'h0);
      tick(40);
      chk("pending", 33'h0, 33'(rdQ.size() + obQ.size() + rfQ.size() + csQ.size()));
      do_reset();
      tick(2);
      chk("inbound ready", 33'h1, {32'h0, ibPushReady});
      chk("byte mask", 33'hF, sdramByteMask);
      give_verdict();
   end
endmodule
